// File: shared/pcs_pkg.sv
// Package with offsets, field positions, reset values and buffer constants of the block.
package pcs_pkg;

  // ----------------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_STATUS     = 8'h04;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFF_BUF_STATUS = 8'h14;

  // ----------------------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------------------
  localparam int          CTRL_AN_ENABLE = 0;
  localparam int          CTRL_ISOLATE   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int          ST_LINK_VALID  = 0;
  localparam int          ST_LINK_SYNC   = 1;
  localparam int          ST_CONFIG      = 2;
  localparam int          ST_IDLE        = 3;
  localparam int          ST_INVALID     = 4;
  localparam logic [4:0]  STATUS_RESET   = 5'h00;
  localparam int          EV_LINK_UP     = 0;
  localparam int          EV_LINK_DOWN   = 1;
  localparam int          EV_INVALID     = 2;
  localparam int          EV_OVERFLOW    = 3;
  localparam int          EV_UNDERFLOW   = 4;
  localparam int          EV_COUNT       = 5;
  localparam logic [4:0]  IRQ_RESET      = 5'h00;

  // ----------------------------------------------------------------------------
  // Receive elastic buffer.
  // ----------------------------------------------------------------------------
  localparam int          CODE_W     = 10;
  localparam int          ENTRY_W    = 11;
  localparam int          ADDR_W     = 4;
  localparam int          DEPTH      = 16;
  localparam logic [4:0]  OCC_LOW    = 5'h06;
  localparam logic [4:0]  OCC_MID    = 5'h08;
  localparam logic [4:0]  OCC_HIGH   = 5'h0a;
  localparam logic [4:0]  OCC_FULL   = 5'h10;
  localparam logic [4:0]  PTR_RESET  = 5'h00;

  typedef enum logic [0:0] {
    BUF_FILL = 1'b0,
    BUF_RUN  = 1'b1
  } pcs_buf_state_t;

endpackage

// File: shared/pcs_mem_if.sv
// Interface joining the status core to its elastic buffer memory.
`timescale 1ns/1ps
interface pcs_mem_if;
  logic                              wrEn;
  logic [pcs_pkg::ADDR_W-1:0]        wrAddr;
  logic [pcs_pkg::ENTRY_W-1:0]       wrData;
  logic [pcs_pkg::ADDR_W-1:0]        rdAddr;
  logic [pcs_pkg::ENTRY_W-1:0]       rdData;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// File: core/pcs_elastic_mem.sv
// Small register-output memory holding received code groups and their idle flags.
`timescale 1ns/1ps
module pcs_elastic_mem (
  input wire logic  clk,
  pcs_mem_if.mem    port
);

  logic [pcs_pkg::ENTRY_W-1:0] store [pcs_pkg::DEPTH];
  logic [pcs_pkg::ENTRY_W-1:0] rdData_reg;

  // Memory cells carry no reset; the read side never consumes an unwritten cell.
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
    rdData_reg <= store[port.rdAddr];
  end

  assign port.rdData = rdData_reg;

endmodule // pcs_elastic_mem

// File: core/pcs_client_status.sv
// Client, status and receive elastic buffer logic of the PCS, with an AHB-Lite register slave.
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module pcs_client_status (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        coreReset,
  input  wire logic        signalDetect,
  input  wire logic        syncAchieved,
  input  wire logic        anComplete,
  input  wire logic        receiving_config_sets,
  input  wire logic        receiving_idle_sets,
  input  wire logic        receiving_invalid_sets,
  input  wire logic [9:0]  rxCodeGroup,
  input  wire logic        rxCodeIdle,
  input  wire logic        rxCodeValid,
  output logic      [9:0]  alignedCode,
  output logic             alignedIdle,
  output logic             alignedValid,
  input  wire logic [7:0]  rxEngineData,
  input  wire logic        rxEngineValid,
  input  wire logic        rxEngineError,
  output logic      [7:0]  client_rx_data,
  output logic             client_rx_valid,
  output logic             client_rx_error,
  input  wire logic [7:0]  client_tx_data,
  input  wire logic        client_tx_enable,
  input  wire logic        client_tx_error,
  output logic      [7:0]  txEngineData,
  output logic             txEngineEnable,
  output logic             txEngineError,
  output logic             clientIsolate,
  output logic      [4:0]  statusVector,
  output logic             irq,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp
);

  // ----------------------------------------------------------------------------
  // Register address decode.
  // ----------------------------------------------------------------------------

  // Maps a byte address to a one-hot register select; unmapped gives zero.
  function automatic logic [5:0] regSelect(input logic [31:0] addr);
    logic [5:0] sel;
    sel = 6'h00;
    if (addr[31:8] == 24'h000000) begin
      unique case (addr[7:0])
        pcs_pkg::OFF_CTRL:       sel = 6'h01;
        pcs_pkg::OFF_STATUS:     sel = 6'h02;
        pcs_pkg::OFF_IRQ_STATUS: sel = 6'h04;
        pcs_pkg::OFF_IRQ_CLEAR:  sel = 6'h08;
        pcs_pkg::OFF_IRQ_ENABLE: sel = 6'h10;
        pcs_pkg::OFF_BUF_STATUS: sel = 6'h20;
        default:                 sel = 6'h00;
      endcase
    end
    return sel;
  endfunction

  logic        coreRst;
  logic        addrPhase;
  logic [5:0]  addrSel;
  logic        wrPend_reg;
  logic [5:0]  wrSel_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] readMux;

  // Either reset clears the core; the active-high one needs no clock edge.
  assign coreRst   = coreReset | ~rstn;
  assign addrPhase = hsel & htrans[1] & hready;
  assign addrSel   = regSelect(haddr);
  assign hreadyout = 1'b1;   // Zero wait states: every register answers at once.
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // ----------------------------------------------------------------------------
  // Control, status and interrupt registers.
  // ----------------------------------------------------------------------------
  logic [1:0]  ctrl_reg;
  logic [4:0]  status_reg;
  logic [4:0]  statusNext;
  logic [4:0]  irqStatus_reg;
  logic [4:0]  irqEnable_reg;
  logic [4:0]  events;
  logic [4:0]  clearMask;
  logic        syncOk;
  logic        mgmtLinkStatus;
  logic        underflowEv;
  logic        overflowEv;
  logic [4:0]  occupancy;
  logic        wrCtrl;
  logic        wrClear;
  logic        wrEnable;

  // Lost light forces the sync indication low whatever the sync machine says.
  assign syncOk         = syncAchieved & signalDetect;
  assign mgmtLinkStatus = syncOk & anComplete;
  assign statusNext[pcs_pkg::ST_LINK_SYNC] = syncOk;
  assign statusNext[pcs_pkg::ST_LINK_VALID] =
      ctrl_reg[pcs_pkg::CTRL_AN_ENABLE] ? mgmtLinkStatus : syncOk;
  assign statusNext[pcs_pkg::ST_CONFIG]  = receiving_config_sets;
  assign statusNext[pcs_pkg::ST_IDLE]    = receiving_idle_sets;
  assign statusNext[pcs_pkg::ST_INVALID] = receiving_invalid_sets;

  // Events are edges of the registered status plus buffer faults.
  assign events[pcs_pkg::EV_LINK_UP] =
      statusNext[pcs_pkg::ST_LINK_VALID] & ~status_reg[pcs_pkg::ST_LINK_VALID];
  assign events[pcs_pkg::EV_LINK_DOWN] =
      ~statusNext[pcs_pkg::ST_LINK_VALID] & status_reg[pcs_pkg::ST_LINK_VALID];
  assign events[pcs_pkg::EV_INVALID] =
      statusNext[pcs_pkg::ST_INVALID] & ~status_reg[pcs_pkg::ST_INVALID];
  assign events[pcs_pkg::EV_OVERFLOW]  = overflowEv;
  assign events[pcs_pkg::EV_UNDERFLOW] = underflowEv;

  // Data-phase write strobes; the clear register is write-only.
  assign wrCtrl    = wrPend_reg & wrSel_reg[0];
  assign wrClear   = wrPend_reg & wrSel_reg[3];
  assign wrEnable  = wrPend_reg & wrSel_reg[4];
  assign clearMask = wrClear ? hwdata[4:0] : 5'h00;
  assign irq       = |(irqStatus_reg & irqEnable_reg);

  // Read data is latched in the address phase so the data phase needs no wait.
  assign readMux = ({32{addrSel[0]}} & {30'h0, ctrl_reg})
                 | ({32{addrSel[1]}} & {27'h0, status_reg})
                 | ({32{addrSel[2]}} & {27'h0, irqStatus_reg})
                 | ({32{addrSel[4]}} & {27'h0, irqEnable_reg})
                 | ({32{addrSel[5]}} & {27'h0, occupancy});

  // Bus slave pipeline registers.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wrPend_reg <= 1'b0;
      wrSel_reg  <= 6'h00;
      hrdata_reg <= 32'h0;
    end else begin
      wrPend_reg <= addrPhase & hwrite;
      wrSel_reg  <= addrSel;
      hrdata_reg <= (addrPhase & ~hwrite) ? readMux : 32'h0;
    end
  end

  // Software registers and status; a hardware event wins over a same-cycle clear.
  always_ff @(posedge clk or posedge coreReset) begin
    if (coreReset) begin
      ctrl_reg      <= pcs_pkg::CTRL_RESET;
      status_reg    <= pcs_pkg::STATUS_RESET;
      irqStatus_reg <= pcs_pkg::IRQ_RESET;
      irqEnable_reg <= pcs_pkg::IRQ_RESET;
    end else if (!rstn) begin
      ctrl_reg      <= pcs_pkg::CTRL_RESET;
      status_reg    <= pcs_pkg::STATUS_RESET;
      irqStatus_reg <= pcs_pkg::IRQ_RESET;
      irqEnable_reg <= pcs_pkg::IRQ_RESET;
    end else begin
      if (wrCtrl) ctrl_reg <= hwdata[1:0];
      if (wrEnable) irqEnable_reg <= hwdata[4:0];
      status_reg    <= statusNext;
      irqStatus_reg <= (irqStatus_reg & ~clearMask) | events;
    end
  end

  assign statusVector  = status_reg;
  assign clientIsolate = ctrl_reg[pcs_pkg::CTRL_ISOLATE];

  // ----------------------------------------------------------------------------
  // Client byte paths.
  // ----------------------------------------------------------------------------

  // Both directions are retimed once; transmit inputs are sampled on clk.
  always_ff @(posedge clk or posedge coreReset) begin
    if (coreReset) begin
      client_rx_data  <= 8'h00;
      client_rx_valid <= 1'b0;
      client_rx_error <= 1'b0;
      txEngineData    <= 8'h00;
      txEngineEnable  <= 1'b0;
      txEngineError   <= 1'b0;
    end else if (!rstn) begin
      client_rx_data  <= 8'h00;
      client_rx_valid <= 1'b0;
      client_rx_error <= 1'b0;
      txEngineData    <= 8'h00;
      txEngineEnable  <= 1'b0;
      txEngineError   <= 1'b0;
    end else begin
      client_rx_data  <= rxEngineData;
      client_rx_valid <= rxEngineValid;
      client_rx_error <= rxEngineError;
      txEngineData    <= client_tx_data;
      txEngineEnable  <= client_tx_enable;
      txEngineError   <= client_tx_error;
    end
  end

  // ----------------------------------------------------------------------------
  // Receive elastic buffer.
  // ----------------------------------------------------------------------------
  pcs_mem_if memBus ();

  pcs_elastic_mem u_mem (
    .clk  (clk),
    .port (memBus.mem)
  );

  pcs_pkg::pcs_buf_state_t bufState_reg;
  pcs_pkg::pcs_buf_state_t bufStateNext;
  logic [4:0]  wrPtr_reg;
  logic [4:0]  rdPtr_reg;
  logic [4:0]  rdPtrNext;
  logic [4:0]  prevPtr;
  logic [15:0] idleFlag_reg;
  logic        full;
  logic        doWrite;
  logic        running;
  logic        canDelete;
  logic        canInsert;
  logic        emit;
  logic        emit_reg;

  assign occupancy = 5'(wrPtr_reg - rdPtr_reg);
  assign prevPtr   = 5'(rdPtr_reg - 5'h01);
  assign full      = (occupancy == pcs_pkg::OCC_FULL);
  assign doWrite   = rxCodeValid & ~full;
  assign overflowEv = rxCodeValid & full;
  assign running   = (bufState_reg == pcs_pkg::BUF_RUN);

  // Only idles are dropped or repeated, so frame bytes are never touched.
  assign canDelete = running & (occupancy > pcs_pkg::OCC_HIGH)
                   & idleFlag_reg[rdPtr_reg[3:0]];
  assign canInsert = running & (occupancy < pcs_pkg::OCC_LOW)
                   & idleFlag_reg[prevPtr[3:0]];
  assign underflowEv = running & (occupancy == 5'h00) & ~canInsert;
  assign emit = running & ~canDelete & ((occupancy != 5'h00) | canInsert);
  assign rdPtrNext = (running & (occupancy != 5'h00) & ~canInsert)
                   ? 5'(rdPtr_reg + 5'h01) : rdPtr_reg;

  // Memory port wiring; an insertion rereads the idle just sent.
  assign memBus.wrEn   = doWrite;
  assign memBus.wrAddr = wrPtr_reg[3:0];
  assign memBus.wrData = {rxCodeIdle, rxCodeGroup};
  assign memBus.rdAddr = canInsert ? prevPtr[3:0] : rdPtr_reg[3:0];

  // Fill to the centre before reading, and refill after an underflow.
  always_comb begin
    bufStateNext = bufState_reg;
    unique case (bufState_reg)
      pcs_pkg::BUF_FILL: if (occupancy >= pcs_pkg::OCC_MID) bufStateNext = pcs_pkg::BUF_RUN;
      pcs_pkg::BUF_RUN:  if (underflowEv) bufStateNext = pcs_pkg::BUF_FILL;
    endcase
  end

  // Pointers, idle shadow flags and the emit pipeline stage.
  always_ff @(posedge clk or posedge coreReset) begin
    if (coreReset) begin
      bufState_reg <= pcs_pkg::BUF_FILL;
      wrPtr_reg    <= pcs_pkg::PTR_RESET;
      rdPtr_reg    <= pcs_pkg::PTR_RESET;
      idleFlag_reg <= 16'h0000;
      emit_reg     <= 1'b0;
    end else if (!rstn) begin
      bufState_reg <= pcs_pkg::BUF_FILL;
      wrPtr_reg    <= pcs_pkg::PTR_RESET;
      rdPtr_reg    <= pcs_pkg::PTR_RESET;
      idleFlag_reg <= 16'h0000;
      emit_reg     <= 1'b0;
    end else begin
      bufState_reg <= bufStateNext;
      rdPtr_reg    <= rdPtrNext;
      emit_reg     <= emit;
      if (doWrite) begin
        wrPtr_reg <= 5'(wrPtr_reg + 5'h01);
        idleFlag_reg[wrPtr_reg[3:0]] <= rxCodeIdle;
      end
    end
  end

  assign alignedValid = emit_reg;
  assign alignedCode  = memBus.rdData[9:0];
  assign alignedIdle  = memBus.rdData[10];

endmodule // pcs_client_status

// File: bench/pcs_client_checker.sv
// Assertions on the client paths, status vector and core reset of the PCS block.
`timescale 1ns/1ps
module pcs_client_checker (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       coreReset,
  input wire logic       signalDetect,
  input wire logic       syncAchieved,
  input wire logic       anComplete,
  input wire logic       receiving_config_sets,
  input wire logic       receiving_idle_sets,
  input wire logic       receiving_invalid_sets,
  input wire logic [7:0] rxEngineData,
  input wire logic       rxEngineValid,
  input wire logic       rxEngineError,
  input wire logic [7:0] client_rx_data,
  input wire logic       client_rx_valid,
  input wire logic       client_rx_error,
  input wire logic [7:0] client_tx_data,
  input wire logic       client_tx_enable,
  input wire logic       client_tx_error,
  input wire logic [7:0] txEngineData,
  input wire logic       txEngineEnable,
  input wire logic       txEngineError,
  input wire logic       clientIsolate,
  input wire logic [4:0] statusVector
);
  // ------------------------------------------------------------
  // Clocking and sequences
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || coreReset);
  // Both resets were off at the previous edge, so registered outputs carry real data.
  sequence s_live;
    $past(rstn) && !$past(coreReset);
  endsequence
  sequence s_full_link;
    s_live ##0 $past(syncAchieved && signalDetect && anComplete);
  endsequence
  sequence s_no_sync;
    s_live ##0 !$past(syncAchieved && signalDetect);
  endsequence
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_tx_copy: assert property (s_live |->
    {txEngineData, txEngineEnable, txEngineError} ==
    $past({client_tx_data, client_tx_enable, client_tx_error})) else $error("tx path slip");
  a_rx_copy: assert property (s_live |->
    {client_rx_data, client_rx_valid, client_rx_error} ==
    $past({rxEngineData, rxEngineValid, rxEngineError})) else $error("rx path slip");
  a_sync_bit: assert property (s_live |->
    statusVector[1] == $past(syncAchieved && signalDetect)) else $error("sync bit wrong");
  a_link_up: assert property (s_full_link |-> statusVector[0])
    else $error("link valid missing");
  a_link_down: assert property (s_no_sync |-> !statusVector[0])
    else $error("link valid without sync");
  a_link_in_sync: assert property (statusVector[0] |-> statusVector[1])
    else $error("link valid above sync");
  a_set_bits: assert property (s_live |-> statusVector[4:2] == $past(
    {receiving_invalid_sets, receiving_idle_sets, receiving_config_sets}))
    else $error("set flags wrong");
  a_core_quiet: assert property (disable iff (!rstn) coreReset |->
    statusVector == 5'h00 && !client_rx_valid && !client_rx_error && !clientIsolate)
    else $error("outputs live in core reset");
endmodule // pcs_client_checker

bind pcs_client_status pcs_client_checker u_checker (.clk, .rstn, .coreReset, .signalDetect,
  .syncAchieved, .anComplete, .receiving_config_sets, .receiving_idle_sets,
  .receiving_invalid_sets, .rxEngineData, .rxEngineValid, .rxEngineError, .client_rx_data,
  .client_rx_valid, .client_rx_error, .client_tx_data, .client_tx_enable, .client_tx_error,
  .txEngineData, .txEngineEnable, .txEngineError, .clientIsolate, .statusVector);

// File: bench/pcs_mac_model.sv
// Behavioural client-side MAC that sources transmit bytes and counts received ones.
`timescale 1ns/1ps
module pcs_mac_model (
  input  wire logic       clk,
  input  wire logic       run,
  output logic      [7:0] txData,
  output logic            txEnable,
  output logic            txError,
  input  wire logic       rxValid,
  output int              rxCount
);
  // Quiet lines at time zero.
  initial begin
    {txData, txEnable, txError} = 10'h000;
  end
  // No transmit elastic buffer is built, so bytes launch on the reference clock.
  always @(posedge clk) begin
    txEnable <= run && (($urandom % 8) != 0);
    txError  <= run && (($urandom % 32) == 0);
    // While run is low the data toggles so a stale byte never passes for a fresh one.
    txData   <= run ? 8'($urandom) : ~txData;
  end
  // One received byte per valid strobe.
  always @(posedge clk) begin
    if (rxValid === 1'b1) begin
      rxCount <= rxCount + 1;
    end
  end
endmodule // pcs_mac_model

// File: bench/tb.sv
// Self-checking bench for the client, status, buffer and register paths of the PCS block.
`timescale 1ns/1ps
module tb;
  // ------------------------------------------------------------
  // Signals and bench state
  // ------------------------------------------------------------
  logic        clk, rstn, coreReset, signalDetect, syncAchieved, anComplete, configSets;
  logic        idleSets, invalidSets, rxCodeIdle, rxCodeValid, alignedIdle, alignedValid;
  logic        rxEngineValid, rxEngineError, clientRxValid, clientRxError, clientTxEnable;
  logic        clientTxError, txEngineEnable, txEngineError, clientIsolate, irq, hsel;
  logic        hwrite, hreadyout, hresp, macRun, anOn, streamOn, padOn;
  logic [9:0]  rxCodeGroup, alignedCode, code;
  logic [10:0] expCode, expPad;
  logic [7:0]  rxEngineData, clientRxData, clientTxData, txEngineData;
  logic [4:0]  statusVector;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  int          nMismatch, samplesChecked, macRxCount, sentValid;
  typedef struct packed {logic [9:0] rx; logic [9:0] tx; logic [4:0] st;} pcs_note_t;
  pcs_note_t   noteQ[$];
  pcs_note_t   note;
  logic [10:0] codeQ[$];
  logic [7:0]  regOffsets [7] = '{pcs_pkg::OFF_CTRL, pcs_pkg::OFF_STATUS,
    pcs_pkg::OFF_IRQ_STATUS, pcs_pkg::OFF_IRQ_CLEAR, pcs_pkg::OFF_IRQ_ENABLE,
    pcs_pkg::OFF_BUF_STATUS, 8'h18};

  // The one slave's ready is the bus ready.
  assign hready = hreadyout;

  pcs_client_status DUT (.clk(clk), .rstn(rstn), .coreReset(coreReset),
    .signalDetect(signalDetect), .syncAchieved(syncAchieved), .anComplete(anComplete),
    .receiving_config_sets(configSets), .receiving_idle_sets(idleSets),
    .receiving_invalid_sets(invalidSets), .rxCodeGroup(rxCodeGroup), .rxCodeIdle(rxCodeIdle),
    .rxCodeValid(rxCodeValid), .alignedCode(alignedCode), .alignedIdle(alignedIdle),
    .alignedValid(alignedValid), .rxEngineData(rxEngineData), .rxEngineValid(rxEngineValid),
    .rxEngineError(rxEngineError), .client_rx_data(clientRxData),
    .client_rx_valid(clientRxValid), .client_rx_error(clientRxError),
    .client_tx_data(clientTxData), .client_tx_enable(clientTxEnable),
    .client_tx_error(clientTxError), .txEngineData(txEngineData),
    .txEngineEnable(txEngineEnable), .txEngineError(txEngineError),
    .clientIsolate(clientIsolate), .statusVector(statusVector), .irq(irq), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  pcs_mac_model u_mac (.clk(clk), .run(macRun), .txData(clientTxData),
    .txEnable(clientTxEnable), .txError(clientTxError), .rxValid(clientRxValid),
    .rxCount(macRxCount));

  // ------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hung run is cut short and counted as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    $display("wrong value at %0t ns: run did not finish", $time);
    report_and_stop();
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Bounded wait for hready; the slave's latency is never assumed.
  task automatic wait_ready();
    repeat (16) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    check(32'h0, 32'h1, "bus ready timeout");
    report_and_stop();
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, 24'h000000, a, 2'b10, wr, 3'b010};
    wait_ready();
    {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
    wait_ready();
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "bus response");
  endtask
  // Random levels and bytes each cycle; the note process below records expectations.
  task automatic stream(input int cycles);
    int base;
    base = macRxCount;
    sentValid = 0;
    {macRun, streamOn} <= 2'b11;
    repeat (cycles) begin
      {syncAchieved, anComplete, configSets, idleSets, invalidSets} <= 5'($urandom);
      signalDetect <= ($urandom % 8) != 0;
      {rxEngineData, rxEngineValid, rxEngineError} <= 10'($urandom);
      @(posedge clk);
      sentValid += rxEngineValid;
    end
    {macRun, streamOn, rxEngineValid} <= 3'b000;
    repeat (3) @(posedge clk);
    check(32'(macRxCount - base), 32'(sentValid), "bytes received");
    $display("test stream with negotiation %0d finished", anOn);
  endtask

  // ------------------------------------------------------------
  // Expectation notes and output monitor
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (streamOn && rstn && !coreReset) begin
      noteQ.push_back({rxEngineData, rxEngineValid, rxEngineError, clientTxData,
        clientTxEnable, clientTxError, invalidSets, idleSets, configSets,
        syncAchieved & signalDetect, syncAchieved & signalDetect & (anComplete | ~anOn)});
    end
  end
  // Registered outputs are compared mid-cycle, when they have settled.
  always @(negedge clk) begin
    if (noteQ.size() > 0) begin
      note = noteQ.pop_front();
      check({22'h0, clientRxData, clientRxValid, clientRxError}, {22'h0, note.rx}, "rx");
      check({22'h0, txEngineData, txEngineEnable, txEngineError}, {22'h0, note.tx}, "tx");
      check({27'h0, statusVector}, {27'h0, note.st}, "status");
    end
    if (alignedValid === 1'b1) begin
      expCode = (codeQ.size() > 0) ? codeQ.pop_front()
              : padOn ? expPad : ~{alignedIdle, alignedCode};
      check({21'h0, alignedIdle, alignedCode}, {21'h0, expCode}, "aligned code");
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hfa5c9c85));
    {rstn, coreReset, syncAchieved, anComplete, configSets, idleSets, invalidSets, rxCodeIdle,
      rxCodeValid, rxEngineValid, rxEngineError, hsel, hwrite, macRun, anOn, streamOn, padOn,
      rxCodeGroup, rxEngineData, haddr, hwdata, htrans, hsize} = '0;
    signalDetect = 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b1, pcs_pkg::OFF_STATUS, 32'h1f);
    foreach (regOffsets[i]) begin
      bus(1'b0, regOffsets[i], 32'h0);
      check(rd, 32'h0, "reset value");
    end
    $display("test reset values finished");
    bus(1'b1, pcs_pkg::OFF_CTRL, 32'h1 << pcs_pkg::CTRL_ISOLATE);
    {syncAchieved, configSets, rxEngineValid} <= 3'b111;
    repeat (2) @(posedge clk);
    check({31'h0, clientIsolate}, 32'h1, "isolate on");
    coreReset <= 1'b1;
    @(negedge clk);
    check({25'h0, statusVector, clientRxValid, clientIsolate}, 32'h0, "core clear");
    @(posedge clk);
    {coreReset, syncAchieved, configSets, rxEngineValid} <= 4'h0;
    @(posedge clk);
    bus(1'b1, pcs_pkg::OFF_CTRL, 32'h0);
    $display("test isolate and core reset finished");
    stream(300);
    bus(1'b1, pcs_pkg::OFF_CTRL, 32'h1 << pcs_pkg::CTRL_AN_ENABLE);
    anOn = 1'b1;
    stream(300);
    // Eight back-to-back codes, the first an idle, come out in order; then the buffer runs dry.
    for (int i = 0; i < 8; i++) begin
      code = 10'($urandom);
      codeQ.push_back({i == 0, code});
      {rxCodeGroup, rxCodeIdle, rxCodeValid} <= {code, i == 0, 1'b1};
      @(posedge clk);
    end
    {rxCodeGroup, rxCodeIdle, rxCodeValid} <= {~code, 2'b00};
    repeat (40) @(posedge clk);
    check(32'(codeQ.size()), 32'h0, "codes delivered");
    bus(1'b0, pcs_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd & (32'h1 << pcs_pkg::EV_UNDERFLOW), 32'h1 << pcs_pkg::EV_UNDERFLOW, "underflow");
    check({31'h0, irq}, 32'h0, "irq masked");
    bus(1'b1, pcs_pkg::OFF_IRQ_ENABLE, 32'h1 << pcs_pkg::EV_UNDERFLOW);
    @(posedge clk);
    check({31'h0, irq}, 32'h1, "irq raised");
    bus(1'b1, pcs_pkg::OFF_IRQ_CLEAR, 32'h1f);
    bus(1'b0, pcs_pkg::OFF_IRQ_STATUS, 32'h0);
    check(rd, 32'h0, "irq cleared");
    check({31'h0, irq}, 32'h0, "irq dropped");
    $display("test buffer and interrupt finished");
    // Idles only: below the low mark the buffer repeats the last idle it sent.
    padOn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      code = 10'($urandom);
      if (i < 3) codeQ.push_back({1'b1, code});
      if (i == 2) expPad = {1'b1, code};
      {rxCodeGroup, rxCodeIdle, rxCodeValid} <= {code, 2'b11};
      @(posedge clk);
    end
    {rxCodeGroup, rxCodeIdle, rxCodeValid} <= {~code, 2'b00};
    repeat (40) @(posedge clk);
    check(32'(codeQ.size()), 32'h0, "idles delivered");
    bus(1'b0, pcs_pkg::OFF_BUF_STATUS, 32'h0);
    check(rd, {27'h0, pcs_pkg::OCC_LOW - 5'h01}, "pad level");
    rstn <= 1'b0;
    @(posedge clk);
    {rstn, padOn} <= 2'b10;
    @(posedge clk);
    $display("test idle insertion finished");
    report_and_stop();
  end
endmodule // tb
